// ---- logic/bsl_pkg.sv ----
package bsl_pkg;

    // -----------------------------------------------------------------
    // boot addresses and vector bytes
    // -----------------------------------------------------------------
    localparam logic [15:0] BOOTLOADER_ADDR = 16'hF800;
    localparam logic [15:0] APPLICATION_ADDR = 16'h0000;
    localparam logic [15:0] API_ENTRY_ADDR = 16'hFFF0;
    localparam logic [7:0] SOFT_VECTOR_DEFAULT = 8'hFC;
    localparam logic [7:0] SOFT_VECTOR_LOW_BYTE = 8'h00;
    localparam logic [7:0] BOOT_STATUS_APP = 8'h00;

    // -----------------------------------------------------------------
    // fuse and lock field positions
    // -----------------------------------------------------------------
    localparam int unsigned JUMP_FUSE_BIT = 6;
    localparam int unsigned LOCK_BIT0 = 0;
    localparam int unsigned LOCK_BIT1 = 1;
    localparam logic [7:0] LOCK_BYTE_RESET = 8'hFF;

    // -----------------------------------------------------------------
    // internal flash top addresses
    // -----------------------------------------------------------------
    localparam logic [15:0] FLASH_TOP_16K = 16'h3FFF;
    localparam logic [15:0] FLASH_TOP_32K = 16'h7FFF;

    // -----------------------------------------------------------------
    // security levels
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        BSL_LEVEL_NONE = 2'h1,
        BSL_LEVEL_NO_PROG = 2'h2,
        BSL_LEVEL_NO_READ = 2'h3
    } bsl_level_type;

    // -----------------------------------------------------------------
    // boot sequencing
    // -----------------------------------------------------------------
    typedef enum logic {
        BSL_HELD,
        BSL_RUN
    } bsl_state_type;

    localparam int unsigned SYNC_WIDTH = 3;
    // edges from dropping our strobe drive until the synced pin shows the strap
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

endpackage : bsl_pkg

// ---- logic/bsl_pin_sync.sv ----
`timescale 1ns/1ps
module bsl_pin_sync #(
    parameter int unsigned WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // pins and synchronised copy
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinSync
);

    // -----------------------------------------------------------------
    // two stages; only the second stage is ever read
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } bsl_sync_type;

    bsl_sync_type sync_r;
    bsl_sync_type sync_nxt;

    always_comb begin
        sync_nxt.stage1 = pinIn;
        sync_nxt.stage2 = sync_r.stage1;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_r.stage1 <= RESET_VALUE;
            sync_r.stage2 <= RESET_VALUE;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign pinSync = sync_r.stage2;

endmodule : bsl_pin_sync

// ---- logic/bsl_boot_select.sv ----
`timescale 1ns/1ps
module bsl_boot_select #(
    parameter bit FLASH_IS_32K = 1'b1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // device pins
    input wire logic resetPinN,
    input wire logic externalFetchSelectPin,
    input wire logic programStoreStrobeIn,
    output logic programStoreStrobeOut,
    output logic programStoreStrobeOe,
    // extra array flash contents
    input wire logic [7:0] hardwareSecurityByte,
    input wire logic [7:0] bootStatusByte,
    input wire logic [7:0] softBootVector,
    // boot result to the core
    output logic coreRun,
    output logic [15:0] bootAddress,
    output logic bootFromStrap,
    // program fetch steering
    input wire logic fetchValid,
    input wire logic [15:0] fetchAddr,
    output logic fetchExternal,
    output logic apiEntryHit,
    // soft security byte access
    input wire logic softSecurityWrEn,
    input wire logic [7:0] softSecurityWrData,
    output logic [7:0] softSecurityRdData,
    output logic [1:0] securityLevel,
    output logic ispProgramAllowed,
    output logic ispVerifyAllowed
);

    // -----------------------------------------------------------------
    // pin synchronisation
    // -----------------------------------------------------------------
    logic [bsl_pkg::SYNC_WIDTH-1:0] pinSync;
    logic resetSyncN;
    logic selectSync;
    logic strobeSync;

    // reset pin reads as asserted until proven otherwise
    bsl_pin_sync #(
        .WIDTH(bsl_pkg::SYNC_WIDTH),
        .RESET_VALUE(3'h0)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pinIn({resetPinN, externalFetchSelectPin, programStoreStrobeIn}),
        .pinSync(pinSync)
    );

    assign {resetSyncN, selectSync, strobeSync} = pinSync;

    // -----------------------------------------------------------------
    // lock level decode
    // -----------------------------------------------------------------
    function automatic bsl_pkg::bsl_level_type lockLevel(input logic [7:0] lockByte);
        if (!lockByte[bsl_pkg::LOCK_BIT1]) begin
            return bsl_pkg::BSL_LEVEL_NO_READ;
        end else if (!lockByte[bsl_pkg::LOCK_BIT0]) begin
            return bsl_pkg::BSL_LEVEL_NO_PROG;
        end
        return bsl_pkg::BSL_LEVEL_NONE;
    endfunction : lockLevel

    // -----------------------------------------------------------------
    // strap decode
    // -----------------------------------------------------------------
    // select high with strobe pulled low asks for the bootloader
    function automatic logic strapSeen(input logic sel, input logic strobe);
        return sel && !strobe;
    endfunction : strapSeen

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        bsl_pkg::bsl_state_type state;
        logic resetPrevN;
        logic strapForce;
        logic coreRun;
        logic [15:0] bootAddr;
        logic fetchExt;
        logic apiHit;
        logic strobeOut;
        logic [7:0] lockByte;
        logic [1:0] strapWait;
    } bsl_boot_type;

    bsl_boot_type boot_r;
    bsl_boot_type boot_nxt;

    logic [15:0] flashTop;
    logic [15:0] resolvedAddr;
    bsl_pkg::bsl_level_type level;

    assign flashTop = FLASH_IS_32K ? bsl_pkg::FLASH_TOP_32K : bsl_pkg::FLASH_TOP_16K;
    assign level = lockLevel(boot_r.lockByte);

    // -----------------------------------------------------------------
    // boot decision
    // -----------------------------------------------------------------
    always_comb begin
        resolvedAddr = bsl_pkg::BOOTLOADER_ADDR;
        if (boot_r.strapForce) begin
            resolvedAddr = bsl_pkg::BOOTLOADER_ADDR;
        end else if (hardwareSecurityByte[bsl_pkg::JUMP_FUSE_BIT]) begin
            resolvedAddr = bsl_pkg::APPLICATION_ADDR;
        end else if (bootStatusByte == bsl_pkg::BOOT_STATUS_APP) begin
            // cleared status byte after programming starts the application
            resolvedAddr = bsl_pkg::APPLICATION_ADDR;
        end else if (softBootVector != bsl_pkg::SOFT_VECTOR_DEFAULT) begin
            resolvedAddr = {softBootVector, bsl_pkg::SOFT_VECTOR_LOW_BYTE};
        end else begin
            resolvedAddr = bsl_pkg::BOOTLOADER_ADDR;
        end
    end

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        boot_nxt = boot_r;
        boot_nxt.resetPrevN = resetSyncN;
        unique case (boot_r.state)
            bsl_pkg::BSL_HELD: begin
                // core stays stopped until the address is fixed
                boot_nxt.coreRun = 1'b0;
                if (boot_r.resetPrevN && !resetSyncN) begin
                    boot_nxt.strapForce = strapSeen(selectSync, strobeSync);
                end
                if (boot_r.strapWait != 2'h0) begin
                    boot_nxt.strapWait = boot_r.strapWait - 2'h1;
                end
                // last settle edge: the synced strobe now shows the strap, not our drive
                if (boot_r.strapWait == 2'h1) begin
                    boot_nxt.strapForce = strapSeen(selectSync, strobeSync);
                end
                if (resetSyncN && boot_r.resetPrevN && (boot_r.strapWait == 2'h0)) begin
                    boot_nxt.bootAddr = resolvedAddr;
                    boot_nxt.coreRun = 1'b1;
                    boot_nxt.state = bsl_pkg::BSL_RUN;
                end
            end
            bsl_pkg::BSL_RUN: begin
                // address frozen; fuse and vector changes wait for reset
                if (!resetSyncN) begin
                    // our strobe drive still sits on the pin here, so the strap is
                    // read only once it has let go; straps must stand that long
                    boot_nxt.strapWait = bsl_pkg::STRAP_SETTLE;
                    boot_nxt.coreRun = 1'b0;
                    boot_nxt.state = bsl_pkg::BSL_HELD;
                end
            end
        endcase
        boot_nxt.fetchExt = !selectSync || (fetchAddr > flashTop);
        boot_nxt.apiHit = boot_r.coreRun && fetchValid && (fetchAddr == bsl_pkg::API_ENTRY_ADDR);
        // strobe active low, only for external fetches
        boot_nxt.strobeOut = !(boot_r.coreRun && fetchValid && boot_nxt.fetchExt);
        if (softSecurityWrEn) begin
            // reserved bits stored as written; only bits 1-0 steer anything
            boot_nxt.lockByte = softSecurityWrData;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            boot_r.state <= bsl_pkg::BSL_HELD;
            boot_r.resetPrevN <= 1'b0;
            boot_r.strapForce <= 1'b0;
            boot_r.coreRun <= 1'b0;
            boot_r.bootAddr <= bsl_pkg::BOOTLOADER_ADDR;
            boot_r.fetchExt <= 1'b0;
            boot_r.apiHit <= 1'b0;
            boot_r.strobeOut <= 1'b1;
            boot_r.lockByte <= bsl_pkg::LOCK_BYTE_RESET;
            boot_r.strapWait <= 2'h0;
        end else begin
            boot_r <= boot_nxt;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign coreRun = boot_r.coreRun;
    assign bootAddress = boot_r.bootAddr;
    assign bootFromStrap = boot_r.strapForce;
    assign fetchExternal = boot_r.fetchExt;
    assign apiEntryHit = boot_r.apiHit;
    assign programStoreStrobeOut = boot_r.strobeOut;
    // pin driven only once running; the strap circuit must let go first
    assign programStoreStrobeOe = boot_r.coreRun;
    assign softSecurityRdData = boot_r.lockByte;
    assign securityLevel = level;
    assign ispProgramAllowed = (level == bsl_pkg::BSL_LEVEL_NONE);
    assign ispVerifyAllowed = (level != bsl_pkg::BSL_LEVEL_NO_READ);

endmodule : bsl_boot_select

// ---- verif/bsl_boot_monitor.sv ----
`timescale 1ns/1ps
module bsl_boot_monitor #(
    parameter bit FLASH_IS_32K = 1'b1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // boot and fetch
    input wire logic externalFetchSelectPin,
    input wire logic programStoreStrobeOut,
    input wire logic coreRun,
    input wire logic [15:0] bootAddress,
    input wire logic bootFromStrap,
    input wire logic fetchValid,
    input wire logic [15:0] fetchAddr,
    input wire logic fetchExternal,
    input wire logic apiEntryHit,
    // lock byte
    input wire logic [7:0] softSecurityRdData,
    input wire logic [1:0] securityLevel,
    input wire logic ispProgramAllowed,
    input wire logic ispVerifyAllowed
);
    localparam logic [15:0] TOP = FLASH_IS_32K ? bsl_pkg::FLASH_TOP_32K : bsl_pkg::FLASH_TOP_16K;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    level_decode_a: assert property (securityLevel == (!softSecurityRdData[1] ? 2'h3 :
        !softSecurityRdData[0] ? 2'h2 : 2'h1)) else $error("lock level decode wrong");
    access_gate_a: assert property (ispProgramAllowed == (securityLevel == 2'h1) &&
        ispVerifyAllowed == (securityLevel != 2'h3)) else $error("isp access gate wrong");
    high_fetch_a: assert property (fetchValid && fetchAddr > TOP |=> fetchExternal)
        else $error("fetch above flash not external");
    // six samples cover the pin synchroniser delay
    low_select_a: assert property ((!externalFetchSelectPin) [*6] ##0 fetchValid |=> fetchExternal)
        else $error("select low fetch not external");
    internal_fetch_a: assert property (externalFetchSelectPin [*6] ##0 (fetchValid && fetchAddr <= TOP)
        |=> !fetchExternal) else $error("flash fetch went external");
    api_entry_a: assert property (coreRun && fetchValid && fetchAddr == bsl_pkg::API_ENTRY_ADDR
        |=> apiEntryHit) else $error("api entry not flagged");
    held_quiet_a: assert property ((!coreRun) [*2] |-> !apiEntryHit && programStoreStrobeOut)
        else $error("fetch activity while held");
    boot_frozen_a: assert property (coreRun && $past(coreRun) |-> $stable(bootAddress))
        else $error("boot address moved while running");
    strap_wins_a: assert property (coreRun && bootFromStrap |-> bootAddress == bsl_pkg::BOOTLOADER_ADDR)
        else $error("strap boot not at bootloader");
    cover property (coreRun && bootFromStrap);
    cover property (apiEntryHit);
    cover property (securityLevel == 2'h3);
endmodule : bsl_boot_monitor

bind bsl_boot_select bsl_boot_monitor #(.FLASH_IS_32K(FLASH_IS_32K)) monitor_i (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .externalFetchSelectPin(externalFetchSelectPin),
    .programStoreStrobeOut(programStoreStrobeOut),
    .coreRun(coreRun),
    .bootAddress(bootAddress),
    .bootFromStrap(bootFromStrap),
    .fetchValid(fetchValid),
    .fetchAddr(fetchAddr),
    .fetchExternal(fetchExternal),
    .apiEntryHit(apiEntryHit),
    .softSecurityRdData(softSecurityRdData),
    .securityLevel(securityLevel),
    .ispProgramAllowed(ispProgramAllowed),
    .ispVerifyAllowed(ispVerifyAllowed)
);

// ---- verif/bsl_strap_model.sv ----
`timescale 1ns/1ps
module bsl_strap_model (
    // strap request from the bench
    input wire logic pullLow,
    // device side of the strobe pin
    input wire logic strobeOut,
    input wire logic strobeOe,
    output logic strobePin
);
    // pulled up when nobody drives; the device drive wins once it runs
    assign strobePin = strobeOe ? strobeOut : !pullLow;
endmodule : bsl_strap_model

// ---- verif/bsl_boot_select_tb.sv ----
`timescale 1ns/1ps
module bsl_boot_select_tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic resetPinN = 1'b1;
    logic externalFetchSelectPin = 1'b1;
    logic pullLow = 1'b0;
    logic fetchValid = 1'b0;
    logic softSecurityWrEn = 1'b0;
    logic [7:0] hardwareSecurityByte = 8'hFF;
    logic [7:0] bootStatusByte = 8'hFF;
    logic [7:0] softBootVector = 8'hFC;
    logic [7:0] softSecurityWrData = 8'hFF;
    logic [15:0] fetchAddr = 16'h0000;
    logic programStoreStrobeIn, programStoreStrobeOut, programStoreStrobeOe, coreRun, bootFromStrap;
    logic fetchExternal, apiEntryHit, ispProgramAllowed, ispVerifyAllowed;
    logic [15:0] bootAddress;
    logic [7:0] softSecurityRdData;
    logic [1:0] securityLevel;
    int bad_count = 0;
    int tests_run = 0;
    always #2.5 ref_clk = ~ref_clk;
    bsl_boot_select DUT (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .resetPinN(resetPinN),
        .externalFetchSelectPin(externalFetchSelectPin),
        .programStoreStrobeIn(programStoreStrobeIn),
        .programStoreStrobeOut(programStoreStrobeOut),
        .programStoreStrobeOe(programStoreStrobeOe),
        .hardwareSecurityByte(hardwareSecurityByte),
        .bootStatusByte(bootStatusByte),
        .softBootVector(softBootVector),
        .coreRun(coreRun),
        .bootAddress(bootAddress),
        .bootFromStrap(bootFromStrap),
        .fetchValid(fetchValid),
        .fetchAddr(fetchAddr),
        .fetchExternal(fetchExternal),
        .apiEntryHit(apiEntryHit),
        .softSecurityWrEn(softSecurityWrEn),
        .softSecurityWrData(softSecurityWrData),
        .softSecurityRdData(softSecurityRdData),
        .securityLevel(securityLevel),
        .ispProgramAllowed(ispProgramAllowed),
        .ispVerifyAllowed(ispVerifyAllowed)
    );
    bsl_strap_model strap (
        .pullLow(pullLow),
        .strobeOut(programStoreStrobeOut),
        .strobeOe(programStoreStrobeOe),
        .strobePin(programStoreStrobeIn)
    );
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic fetch(input logic [15:0] a, input logic ext, input logic run);
        @(posedge ref_clk);
        fetchValid <= 1'b1;
        fetchAddr <= a;
        @(posedge ref_clk);
        fetchValid <= 1'b0;
        #1;
        check(fetchExternal, ext);
        check(apiEntryHit, run && a == 16'hFFF0);
        check(programStoreStrobeOut, !(run && ext));
    endtask : fetch
    task automatic wr(input logic [7:0] d, input logic [1:0] lvl);
        @(posedge ref_clk);
        softSecurityWrEn <= 1'b1;
        softSecurityWrData <= d;
        @(posedge ref_clk);
        softSecurityWrEn <= 1'b0;
        #1;
        check(softSecurityRdData, d);
        check(securityLevel, lvl);
        check(ispProgramAllowed, lvl == 2'h1);
        check(ispVerifyAllowed, lvl != 2'h3);
    endtask : wr
    task automatic boot(input logic s, input logic st, input logic [7:0] h, input logic [7:0] b,
                        input logic [7:0] v, input logic [15:0] exp);
        @(posedge ref_clk);
        externalFetchSelectPin <= s;
        // st is the strobe pin level wanted during reset; low means strapped
        pullLow <= !st;
        hardwareSecurityByte <= h;
        bootStatusByte <= b;
        softBootVector <= v;
        repeat (4) @(posedge ref_clk);
        resetPinN <= 1'b0;
        repeat (5) @(posedge ref_clk);
        // straps turned round after capture must not count
        pullLow <= st;
        fetch(16'hFFF0, 1'b1, 1'b0);
        @(posedge ref_clk);
        resetPinN <= 1'b1;
        repeat (5) @(posedge ref_clk);
        pullLow <= 1'b0;
        hardwareSecurityByte <= ~h;
        bootStatusByte <= ~b;
        softBootVector <= ~v;
        #1;
        check(coreRun, 1'b1);
        check(bootAddress, exp);
        check(bootFromStrap, s && !st);
        repeat (3) @(posedge ref_clk);
        #1;
        check(bootAddress, exp);
    endtask : boot
    task automatic results();
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1;
        check(softSecurityRdData, 8'hFF);
        check(securityLevel, 2'h1);
        repeat (5) @(posedge ref_clk);
        #1;
        check(bootAddress, 16'h0000);
        boot(1'b1, 1'b1, 8'hFF, 8'hFF, 8'hFC, 16'h0000);
        boot(1'b1, 1'b0, 8'hFF, 8'h00, 8'h12, 16'hF800);
        boot(1'b0, 1'b0, 8'hBF, 8'h00, 8'h12, 16'h0000);
        boot(1'b1, 1'b1, 8'hBF, 8'hFF, 8'h12, 16'h1200);
        boot(1'b1, 1'b1, 8'hBF, 8'hFF, 8'hFC, 16'hF800);
        fetch(16'h7FFF, 1'b0, 1'b1);
        fetch(16'h8000, 1'b1, 1'b1);
        fetch(16'hFFF0, 1'b1, 1'b1);
        boot(1'b0, 1'b1, 8'hFF, 8'hFF, 8'hFC, 16'h0000);
        fetch(16'h0000, 1'b1, 1'b1);
        // bits 7 down to 2 are always written as one
        wr(8'hFE, 2'h2);
        wr(8'hFD, 2'h3);
        wr(8'hFC, 2'h3);
        wr(8'hFF, 2'h1);
        results();
    end
    initial begin
        #20000;
        bad_count++;
        results();
    end
endmodule : bsl_boot_select_tb
